//--- core/eeprom_pins.sv
// pin-level serial interface of a small spi eeprom with its array
`timescale 1ns/1ps
module eeprom_pins import eeprom_pins_pkg::*; (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic shift_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic write_protect_n,
	input wire logic pause_n,
	output logic serial_out,
	output logic serial_out_oe,
	output logic write_busy
);
	////////////////////////////////////////////////////////////////////////////////
	// system-side synchronised pins and state
	logic wp_n_s;
	logic busy;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [15:0] busy_cnt;
	logic [15:0] next_busy_cnt;
	logic [7:0] mem [array_words];
	logic fifo_valid;
	logic fifo_ready;
	logic [fifo_width-1:0] fifo_data;
	logic [fifo_width-1:0] req_data;
	logic req_valid;
	logic req_ready;
	logic cs_n_s;
	// link-to-system event toggles and their three-flop synchronisers
	logic wren_tgl;
	logic wrdi_tgl;
	logic wren_s;
	logic wrdi_s;
	logic wren_d;
	logic wrdi_d;
	logic wren_e;
	logic wrdi_e;
	logic [fifo_width-1:0] link_req;
	logic link_req_tgl;
	logic link_req_s;
	logic link_req_d;
	logic link_req_e;
	logic req_pend;
	logic next_req_pend;

	////////////////////////////////////////////////////////////////////////////////
	// link-side state, clocked by the shift clock
	logic held;
	logic paused;
	phase_t phase;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic [2:0] op;
	logic a8;
	logic [addr_width-1:0] addr;
	logic [7:0] tx;
	logic so_en;
	logic [7:0] status_l1;
	logic [7:0] status_l2;
	logic [7:0] rd_l1;
	logic [7:0] rd_l2;
	logic [7:0] rd_word;
	logic [7:0] shin;

	eeprom_sync3 #(.init(1'b1)) u_wp (
		.clk(clk_sys),
		.nrst(nrst),
		.din(write_protect_n),
		.dout(wp_n_s)
	);

	// the write engine may only run on a settled deselect, so select is synchronised too
	eeprom_sync3 #(.init(1'b1)) u_cs (
		.clk(clk_sys),
		.nrst(nrst),
		.din(chip_select_n),
		.dout(cs_n_s)
	);

	// pause acts at once on rises; the fall after a paused rise stays frozen as well
	always_ff @(posedge shift_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			held <= 1'b0;
		end else begin
			held <= paused;
		end
	end
	assign paused = ~pause_n;

	assign shin = {shreg[6:0], serial_in};

	// rising edge capture; select high restarts the transaction
	always_ff @(posedge shift_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			phase <= ph_instr;
			bit_cnt <= '0;
			shreg <= '0;
			op <= '0;
			a8 <= 1'b0;
			addr <= '0;
		end else if (!paused) begin
			shreg <= shin;
			bit_cnt <= bit_cnt + 3'd1;
			if (bit_cnt == 3'd7) begin
				unique case (phase)
					ph_instr: begin
						op <= shin[2:0];
						a8 <= shin[3];
						if (shin[7:4] != instr_upper_zero) begin
							op <= '0; // a dead frame must never pass for a write disable
							phase <= ph_dead;
						end else if (shin[2:0] == op_array_read || shin[2:0] == op_array_write) begin
							phase <= ph_addr;
						end else if (shin[2:0] == op_status_read) begin
							phase <= ph_status;
						end else if (shin[2:0] == op_status_store) begin
							phase <= ph_wdata;
						end else if (shin[2:0] == op_write_enable) begin
							phase <= ph_dead;
						end else if (shin[2:0] == op_write_disable) begin
							phase <= ph_dead;
						end else begin
							phase <= ph_dead;
						end
					end
					ph_addr: begin
						addr <= {a8, shin};
						phase <= (op == op_array_read) ? ph_rdata : ph_wdata;
					end
					ph_wdata: begin
						addr <= addr + 1'b1;
					end
					ph_rdata: begin
						addr <= addr + 1'b1;
					end
					ph_status: begin
					end
					ph_dead: begin
					end
				endcase
			end
		end
	end

	// write disable toggle fires on the select rising edge
	always_ff @(posedge chip_select_n or negedge nrst) begin
		if (!nrst) begin
			wrdi_tgl <= 1'b0;
		end else begin
			if (op == op_write_disable && phase == ph_dead) begin
				wrdi_tgl <= ~wrdi_tgl;
			end
		end
	end

	// event toggles sit outside the select reset, so a frame end never swallows one
	always_ff @(posedge shift_clock or negedge nrst) begin
		if (!nrst) begin
			wren_tgl <= 1'b0;
			link_req_tgl <= 1'b0;
			link_req <= '0;
		end else if (!chip_select_n && !paused && bit_cnt == 3'd7) begin
			if (phase == ph_instr && shin[7:4] == instr_upper_zero
				&& shin[2:0] == op_write_enable) begin
				wren_tgl <= ~wren_tgl;
			end
			// data word stays put until the next byte, long after the toggle is seen
			if (phase == ph_wdata) begin
				link_req <= {op == op_status_store, addr, shin};
				link_req_tgl <= ~link_req_tgl;
			end
		end
	end

	// falling edge output; new byte loaded at each byte boundary of a status or read phase
	always_ff @(negedge shift_clock or posedge chip_select_n) begin
		if (chip_select_n) begin
			tx <= '0;
			so_en <= 1'b0;
		end else if (!held) begin
			if (bit_cnt == 3'd0 && phase == ph_status) begin
				tx <= status_l2;
				so_en <= 1'b1;
			end else if (bit_cnt == 3'd0 && phase == ph_rdata) begin
				tx <= rd_word;
				so_en <= 1'b1;
			end else begin
				tx <= {tx[6:0], 1'b0};
			end
		end
	end
	assign rd_word = mem[addr];

	// status crosses into the link clock through two flops; read data comes straight from the array
	always_ff @(posedge shift_clock) begin
		status_l1 <= status;
		status_l2 <= status_l1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// system side: event detection, latch flag, write engine
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wren_s <= 1'b0;
			wren_d <= 1'b0;
			wren_e <= 1'b0;
			link_req_s <= 1'b0;
			link_req_d <= 1'b0;
			link_req_e <= 1'b0;
			wrdi_s <= 1'b0;
			wrdi_d <= 1'b0;
			wrdi_e <= 1'b0;
		end else begin
			// only the settled second and third stages are compared, never the first
			wren_s <= wren_tgl;
			wren_d <= wren_s;
			wren_e <= wren_d;
			link_req_s <= link_req_tgl;
			link_req_d <= link_req_s;
			link_req_e <= link_req_d;
			wrdi_s <= wrdi_tgl;
			wrdi_d <= wrdi_s;
			wrdi_e <= wrdi_d;
		end
	end

	always_comb begin
		next_req_pend = req_pend;
		if (link_req_d != link_req_e) begin
			next_req_pend = 1'b1;
		end else if (req_valid && req_ready) begin
			next_req_pend = 1'b0;
		end
	end
	assign req_valid = req_pend;
	assign req_data = link_req;

	eeprom_fifo #(.width(fifo_width), .depth(fifo_depth)) u_fifo (
		.clk(clk_sys),
		.nrst(nrst),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data(req_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// the engine drains one request at a time and stays busy for the write time after each request taken with the latch flag set
	assign fifo_ready = !busy && cs_n_s;
	always_comb begin
		next_status = status;
		next_busy_cnt = busy_cnt;
		if (busy_cnt != '0) begin
			next_busy_cnt = busy_cnt - 16'd1;
			if (busy_cnt == 16'd1) begin
				next_status[write_latch_bit] = 1'b0;
			end
		end
		if (wrdi_d != wrdi_e) begin
			next_status[write_latch_bit] = 1'b0;
		end
		if (wren_d != wren_e) begin
			next_status[write_latch_bit] = 1'b1;
		end
		if (fifo_valid && fifo_ready && status[write_latch_bit]) begin
			next_busy_cnt = write_cycles[15:0];
			if (fifo_data[fifo_width-1]) begin
				next_status[bp_hi_bit] = fifo_data[bp_hi_bit];
				next_status[bp_lo_bit] = fifo_data[bp_lo_bit];
			end
		end
		if (!wp_n_s) begin
			next_status[write_latch_bit] = 1'b0;
		end
		next_status[status_busy_bit] = (next_busy_cnt != '0);
	end
	assign busy = (busy_cnt != '0);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			status <= status_reset;
			busy_cnt <= '0;
			req_pend <= 1'b0;
			write_busy <= 1'b0;
		end else begin
			status <= next_status;
			busy_cnt <= next_busy_cnt;
			req_pend <= next_req_pend;
			write_busy <= busy; // stands for the full write_cycles span
		end
	end

	// array store happens only after the latch flag check above
	always_ff @(posedge clk_sys) begin
		if (fifo_valid && fifo_ready && status[write_latch_bit] && !fifo_data[fifo_width-1]) begin
			mem[fifo_data[16:8]] <= fifo_data[7:0];
		end
	end

	// output pin: released when deselected, paused or not in a read phase
	assign serial_out = tx[7];
	assign serial_out_oe = so_en && !chip_select_n && !paused;
endmodule

//--- core/eeprom_pins_pkg.sv
// shared constants for the serial eeprom pin interface
package eeprom_pins_pkg;
	// instruction field positions and codes, low three bits plus upper nibble
	localparam logic [3:0] instr_upper_zero = 4'h0;
	localparam logic [2:0] op_write_enable = 3'h6;
	localparam logic [2:0] op_write_disable = 3'h4;
	localparam logic [2:0] op_status_read = 3'h5;
	localparam logic [2:0] op_status_store = 3'h1;
	localparam logic [2:0] op_array_read = 3'h3;
	localparam logic [2:0] op_array_write = 3'h2;
	// status register bit positions
	localparam int status_busy_bit = 0;
	localparam int write_latch_bit = 1;
	localparam int bp_lo_bit = 2;
	localparam int bp_hi_bit = 3;
	// reset values and widths
	localparam logic [7:0] status_reset = 8'h00;
	localparam int addr_width = 9;
	localparam int array_words = 512;
	localparam int fifo_width = 18;
	localparam int fifo_depth = 32;
	// internal write time, in ns and in system cycles
	localparam int write_time_ns = 4000;
	localparam int clk_period_ns = 4;
	localparam int write_cycles = (write_time_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int bit_count_width = 3;
	// link-side transaction phases
	typedef enum logic [5:0] {
		ph_instr = 6'h01,
		ph_addr = 6'h02,
		ph_wdata = 6'h04,
		ph_rdata = 6'h08,
		ph_status = 6'h10,
		ph_dead = 6'h20
	} phase_t;
endpackage

//--- core/eeprom_sync3.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module eeprom_sync3 import eeprom_pins_pkg::*; #(
	parameter logic init = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic s1;
	logic s2;
	logic s3;
	logic next_dout;

	// second and third stages must agree before the output moves; s1 feeds only s2
	always_comb begin
		next_dout = dout;
		if (s2 == s3) begin
			next_dout = s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1 <= init;
			s2 <= init;
			s3 <= init;
			dout <= init;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule

//--- core/eeprom_fifo.sv
// parameterised valid/ready fifo for write requests
`timescale 1ns/1ps
module eeprom_fifo #(
	parameter int width = 18,
	parameter int depth = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw-1:0] rd_ptr;
	logic [aw-1:0] wr_ptr;
	logic [aw:0] count;
	logic [aw-1:0] next_rd_ptr;
	logic [aw-1:0] next_wr_ptr;
	logic [aw:0] next_count;
	logic push;
	logic pop;

	// honest full and empty come straight from the occupancy count
	always_comb begin
		in_ready = (count != depth[aw:0]);
		out_valid = (count != '0);
		out_data = mem[rd_ptr];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count + {{aw{1'b0}}, push} - {{aw{1'b0}}, pop};
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count <= next_count;
		end
	end

	// storage has no reset; only written entries are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

//--- test/eeprom_pins_assertions.sv
// assertion checker bound to the eeprom pin interface
`timescale 1ns/1ps
module eeprom_pins_checker import eeprom_pins_pkg::*; (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic shift_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	input wire logic write_protect_n,
	input wire logic pause_n,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic write_busy
);
	int busy_cnt;
	int wp_cnt;
	int next_busy_cnt;
	int next_wp_cnt;
	// long spans are counted here, a repetition would unroll too far
	always_comb begin
		next_busy_cnt = write_busy ? busy_cnt + 1 : 0;
		next_wp_cnt = write_protect_n ? 0 : wp_cnt + 1;
	end
	always_ff @(posedge clk_sys) begin
		busy_cnt <= next_busy_cnt;
		wp_cnt <= next_wp_cnt;
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	desel_release_a: assert property (chip_select_n [*2] |-> !serial_out_oe)
		else $error("output driven while deselected");
	pause_release_a: assert property ((!pause_n && !shift_clock) [*2] |-> !serial_out_oe)
		else $error("output driven while paused");
	out_hold_a: assert property (shift_clock && $past(shift_clock) && !chip_select_n
		&& $past(!chip_select_n) |-> $stable(serial_out))
		else $error("output changed while clock high");
	oe_rise_a: assert property ($rose(serial_out_oe) |-> !chip_select_n && pause_n
		&& !shift_clock)
		else $error("output enabled at a wrong moment");
	pause_freeze_a: assert property (!pause_n && $past(!pause_n && !shift_clock)
		|-> $stable(serial_out))
		else $error("output moved during pause");
	protect_block_a: assert property (wp_cnt > 8 |-> !$rose(write_busy))
		else $error("write started under protect");
	busy_start_a: assert property ($rose(write_busy) |-> chip_select_n)
		else $error("write started while selected");
	busy_span_a: assert property ($fell(write_busy) |-> busy_cnt >= write_cycles)
		else $error("internal write cut short");
	cover property ($rose(write_busy));
	cover property ($rose(serial_out_oe));
	cover property (!pause_n && !chip_select_n);
endmodule
////////////////////////////////////////
bind eeprom_pins eeprom_pins_checker eeprom_pins_checker_i (.clk_sys, .nrst, .shift_clock,
	.chip_select_n, .serial_in, .write_protect_n, .pause_n, .serial_out, .serial_out_oe,
	.write_busy);

//--- test/spi_host_model.sv
// behavioural spi host for the eeprom pins
`timescale 1ns/1ps
module spi_host_model (
	output logic shift_clock,
	output logic chip_select_n,
	output logic serial_in,
	output logic pause_n,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	int half = 16;
	logic oe_seen = 1'b0;
	logic last = 1'b0;
	// clock idles low and stands still between frames
	initial begin
		shift_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		pause_n = 1'b1;
	end
	// a frame opens on a select fall, the instruction byte first
	task automatic sel();
		chip_select_n = 1'b0;
		oe_seen = 1'b0;
		#(half + 0.7);
	endtask
	task automatic desel();
		#(half);
		chip_select_n = 1'b1;
		#(3 * half);
	endtask
	// msb first, data set while the clock is low
	task automatic xbyte(input logic [7:0] tx, input int n, input int p, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i >= 8 - n; i--) begin
			if (7 - i == p) begin
				hold_pause();
			end
			serial_in = tx[i];
			#(half);
			shift_clock = 1'b1;
			rx[i] = serial_out_oe ? serial_out : ~last; // released line reads as the previous bit inverted
			last = rx[i];
			oe_seen |= serial_out_oe;
			#(half);
			shift_clock = 1'b0;
		end
		serial_in = ~serial_in;
	endtask
	// pause with clock low and select kept low, wiggling clock and data
	task automatic hold_pause();
		#(half / 2);
		pause_n = 1'b0;
		for (int k = 0; k < 3; k++) begin
			serial_in = 1'($urandom);
			#(half) shift_clock = 1'b1;
			#(half) shift_clock = 1'b0;
		end
		#(half / 2);
		pause_n = 1'b1;
	endtask
endmodule

//--- test/eeprom_pins_tb.sv
// self-checking bench for the eeprom pin interface
`timescale 1ns/1ps
module eeprom_pins_tb import eeprom_pins_pkg::*;;
	logic clk_sys = 1'b0;
	logic nrst = 1'b1;
	logic write_protect_n = 1'b1;
	wire shift_clock, chip_select_n, serial_in, pause_n, serial_out, serial_out_oe, write_busy;
	int error_cnt = 0;
	int check_count = 0;
	int pz = 9;
	logic [7:0] rx;
	always #2 clk_sys = ~clk_sys;
	eeprom_pins eeprom_pins_i (.clk_sys, .nrst, .shift_clock, .chip_select_n, .serial_in,
		.write_protect_n, .pause_n, .serial_out, .serial_out_oe, .write_busy);
	spi_host_model spi_host_model_i (.shift_clock, .chip_select_n, .serial_in, .pause_n,
		.serial_out, .serial_out_oe);
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] opc(input logic [2:0] op, input logic a8);
		return {instr_upper_zero, a8, op};
	endfunction
	// whole frame: opcode, then address if nb is 2, then one data byte if nb > 0
	task automatic frame(input logic [2:0] op, input logic [8:0] a, input logic [7:0] d,
		input int nb, output logic [7:0] r);
		spi_host_model_i.sel();
		spi_host_model_i.xbyte(opc(op, a[8]), 8, 9, r);
		if (nb > 1) spi_host_model_i.xbyte(a[7:0], 8, 9, r);
		if (nb > 0) spi_host_model_i.xbyte(d, 8, pz, r);
		spi_host_model_i.desel();
	endtask
	// waits are bounded so a stuck write shows up as a mismatch
	task automatic wait_write(input logic want);
		int n;
		logic [7:0] r;
		for (n = 0; n < 300 && write_busy !== 1'b1; n++)
			@(negedge clk_sys);
		check("write busy", {7'h00, want}, {7'h00, write_busy === 1'b1});
		if (want) begin
			frame(op_status_read, 0, 0, 1, r);
			check("busy bit", 8'h01, {7'h00, r[0]});
		end
		for (n = 0; n < 1500 && write_busy !== 1'b0; n++)
			@(negedge clk_sys);
		check("write done", 8'h00, {7'h00, write_busy});
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		logic [8:0] a;
		logic [7:0] d;
		void'($urandom(69902));
		@(negedge clk_sys) nrst = 1'b0; // a real falling edge clears the link-side toggles
		repeat (4) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		frame(op_status_read, 0, 0, 1, rx);
		check("status", status_reset, rx);
		frame(op_write_enable, 0, 0, 0, rx);
		frame(op_status_read, 0, 0, 1, rx);
		check("latch set", 8'h02, rx);
		frame(op_write_disable, 0, 0, 0, rx);
		frame(op_status_read, 0, 0, 1, rx);
		check("latch off", 8'h00, rx);
		// writes at both address ends and at random, slow link on odd turns
		for (int t = 0; t < 4; t++) begin
			a = t == 0 ? 9'h1ff : (t == 1 ? 9'h000 : 9'($urandom));
			d = 8'($urandom);
			spi_host_model_i.half = t[0] ? 40 : 16;
			frame(op_write_enable, 0, 0, 0, rx);
			frame(op_array_write, a, d, 2, rx);
			wait_write(1'b1);
			pz = t;
			frame(op_array_read, a, 0, 2, rx);
			pz = 9;
			check("readback", d, rx);
			frame(op_status_read, 0, 0, 1, rx);
			check("latch after write", 8'h00, rx);
		end
		frame(op_write_enable, 0, 0, 0, rx);
		@(negedge clk_sys) write_protect_n = 1'b0;
		frame(op_status_read, 0, 0, 1, rx);
		check("latch protected", 8'h00, rx);
		frame(op_write_enable, 0, 0, 0, rx);
		frame(op_array_write, a, ~d, 2, rx);
		wait_write(1'b0);
		frame(op_array_read, a, 0, 2, rx);
		check("array kept", d, rx);
		@(negedge clk_sys) write_protect_n = 1'b1;
		frame(op_write_enable, 0, 0, 0, rx);
		frame(op_status_store, 0, 8'h00, 1, rx);
		wait_write(1'b1);
		// undefined opcode keeps the output released for the rest of the frame
		spi_host_model_i.sel();
		spi_host_model_i.xbyte(8'h15, 8, 9, rx);
		spi_host_model_i.xbyte(8'h00, 8, 9, rx);
		spi_host_model_i.desel();
		check("bad opcode oe", 8'h00, {7'h00, spi_host_model_i.oe_seen});
		spi_host_model_i.sel();
		spi_host_model_i.xbyte(opc(op_write_enable, 1'b0), 5, 9, rx);
		spi_host_model_i.desel();
		frame(op_status_read, 0, 0, 1, rx);
		check("after partial", 8'h00, rx);
		wrap_up();
	end
	// watchdog well past the expected run length
	initial begin
		#200us;
		error_cnt++;
		wrap_up();
	end
endmodule
